// *** src/dlps_pkg.sv ***
// Purpose: constants and types of the line-program DMA sequencer
// Assumes: 12 channels, 32-bit dwords, byte addresses
// Notes: instruction layout and channel directions fixed here
// ===========================================================
package dlps_pkg;
  localparam int NCH = 12;
  localparam int DW = 32;
  localparam int FIFO_DEPTH = 4;
  localparam int ONCHIP_AW = 24;
  localparam logic [NCH-1:0] UP_CHANS = 12'hfc0;
  // ===========================================================
  // opcode and field layout of dword 0
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 28;
  localparam int START_BIT = 27;
  localparam int END_BIT = 26;
  localparam int INSTR_INTERRUPT_ONE_BIT = 25;
  localparam int INSTR_INTERRUPT_TWO_BIT = 24;
  localparam int ONCHIP_BIT = 23;
  localparam int CNT_HI = 17;
  localparam int CNT_LO = 16;
  localparam int COUNT_HI = 11;
  localparam logic [3:0] OP_STORE = 4'h1;
  localparam logic [3:0] OP_CSTORE = 4'h2;
  localparam logic [3:0] OP_FETCH = 4'h3;
  localparam logic [3:0] OP_CFETCH = 4'h4;
  localparam logic [3:0] OP_DISCARD = 4'h5;
  localparam logic [3:0] OP_BRANCH = 4'h6;
  localparam logic [3:0] OP_REGDUMP = 4'h7;
  localparam logic [3:0] OP_CONSTDUMP = 4'h8;
  localparam logic [3:0] OP_MASKWR = 4'h9;
  localparam logic [1:0] CNT_INC = 2'h1;
  localparam logic [1:0] CNT_CLR = 2'h3;
  localparam logic [11:0] NO_ERR = 12'h000;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_EXEC, ST_XFER, ST_REGRD, ST_REGWR, ST_HOSTWR,
    ST_DONE
  } dlps_st_t;

  typedef struct packed {
    logic req;
    logic we;
    logic onchip;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dlps_mem_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [ONCHIP_AW-1:0] addr;
    logic [31:0] wdata;
  } dlps_reg_t;

  typedef struct packed {
    dlps_st_t st;
    logic [3:0] chan;
    logic [1:0] wIdx;
    logic [3:0][31:0] w;
    logic [10:0] beats;
    logic [NCH-1:0][31:0] pc;
    logic [NCH-1:0] onchip;
    logic [NCH-1:0][31:0] addr;
    logic [NCH-1:0] inLine;
    logic [NCH-1:0] running;
    logic [NCH-1:0][15:0] evCnt;
    logic [NCH-1:0] syncErr;
    logic [NCH-1:0] instr_interrupt_one;
    logic [NCH-1:0] instr_interrupt_two;
    dlps_mem_t mem;
    dlps_reg_t rg;
    logic [31:0] regVal;
    logic upValid;
    logic [31:0] upData;
  } dlps_state_t;

  function automatic logic [2:0] instrLen(input logic [3:0] op);
    unique case (op)
      OP_STORE, OP_FETCH, OP_BRANCH: instrLen = 3'd2;
      OP_REGDUMP, OP_CONSTDUMP: instrLen = 3'd3;
      OP_MASKWR: instrLen = 3'd4;
      default: instrLen = 3'd1;
    endcase
  endfunction : instrLen
endpackage : dlps_pkg

// *** src/dlps_top.sv ***
// Purpose: line-program DMA sequencer for 12 stream channels
// Assumes: memory, register and peripheral ports on core_clk
// Notes: one instruction in flight; channels served round robin
`timescale 1ns/1ns

// ===========================================================
// store-data FIFO
module dlps_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rstnSync,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } dlps_fifo_st_t;
  dlps_fifo_st_t s, n;
  logic push, pop;

  always_comb begin
    n = s;
    push = inValid && s.rdy;
    pop = outReady && (s.cnt != '0);
    if (push) begin
      n.mem[s.wp] = inData;
      n.wp = s.wp + 1'b1;
    end
    if (pop) begin
      n.rp = s.rp + 1'b1;
    end
    n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    n.rdy = n.cnt != (AW+1)'(DEPTH);
  end

  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign inReady = s.rdy;
  assign outValid = s.cnt != '0;
  assign outData = s.mem[s.rp];
endmodule : dlps_fifo

// ===========================================================
// sequencer
module dlps_top (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic sequencerRun,
  input wire logic [11:0] progEnable,
  input wire logic [11:0] fifoEnable,
  input wire logic [11:0][31:0] initPc,
  input wire logic [11:0] initOnchip,
  input wire logic [11:0] syncErrClr,
  output dlps_pkg::dlps_mem_t memOut,
  input wire logic memAck,
  input wire logic [31:0] memRdata,
  output dlps_pkg::dlps_reg_t regOut,
  input wire logic regAck,
  input wire logic [31:0] regRdata,
  input wire logic periphValid,
  input wire logic [3:0] periphChan,
  input wire logic [31:0] periphData,
  output logic periphReady,
  output logic upValid,
  output logic [31:0] upData,
  output logic [11:0] irqOne,
  output logic [11:0] irqTwo,
  output logic [11:0] syncErr,
  output logic [11:0][15:0] evCount
);
  dlps_pkg::dlps_state_t s, n;
  logic [1:0] rstPipe_q;
  logic rstnSync;
  logic fifoOutValid, fifoPop, fifoPush;
  logic [31:0] fifoData;
  logic [3:0] op;
  logic [11:0] cnt;
  logic startF, endF, isUp, mism;
  logic [3:0] c;
  logic [31:0] base;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstPipe_q <= 2'h0;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end
  assign rstnSync = rstPipe_q[1];

  assign fifoPush = periphValid && fifoEnable[periphChan];

  dlps_fifo #(.WIDTH(dlps_pkg::DW), .DEPTH(dlps_pkg::FIFO_DEPTH)) uFifo (
    .clk(core_clk),
    .rstnSync(rstnSync),
    .inValid(fifoPush),
    .inData(periphData),
    .inReady(periphReady),
    .outValid(fifoOutValid),
    .outData(fifoData),
    .outReady(fifoPop)
  );

  function automatic logic [3:0] nextChan(input logic [3:0] cur,
                                          input logic [11:0] ok);
    logic [3:0] k;
    nextChan = 4'hf;
    for (int i = 12; i >= 1; i--) begin
      k = 4'((32'(cur) + i) % dlps_pkg::NCH);
      if (ok[k]) begin
        nextChan = k;
      end
    end
  endfunction : nextChan

  assign op = s.w[0][dlps_pkg::OPC_HI:dlps_pkg::OPC_LO];
  assign cnt = s.w[0][dlps_pkg::COUNT_HI:0];
  assign startF = s.w[0][dlps_pkg::START_BIT];
  assign endF = s.w[0][dlps_pkg::END_BIT];
  assign isUp = dlps_pkg::UP_CHANS[s.chan];

  always_comb begin
    unique case (op)
      dlps_pkg::OP_STORE, dlps_pkg::OP_FETCH, dlps_pkg::OP_DISCARD:
        mism = startF == s.inLine[s.chan];
      dlps_pkg::OP_CSTORE: mism = !s.inLine[s.chan] || isUp;
      dlps_pkg::OP_CFETCH: mism = !s.inLine[s.chan] || !isUp;
      default: mism = 1'b0;
    endcase
  end

  always_comb begin
    n = s;
    fifoPop = 1'b0;
    c = 4'h0;
    base = 32'h0;
    n.instr_interrupt_one = '0;
    n.instr_interrupt_two = '0;
    n.upValid = 1'b0;
    // set wins over clear
    n.syncErr = s.syncErr & ~syncErrClr;
    for (int i = 0; i < dlps_pkg::NCH; i++) begin
      if (!progEnable[i]) begin
        n.running[i] = 1'b0;
      end else if (!s.running[i]) begin
        n.running[i] = 1'b1;
        n.pc[i] = initPc[i];
        n.onchip[i] = initOnchip[i];
        n.inLine[i] = 1'b0;
      end
    end
    unique case (s.st)
      dlps_pkg::ST_IDLE: begin
        c = nextChan(s.chan, s.running & progEnable);
        if (c != 4'hf) begin
          n.chan = c;
          n.wIdx = 2'h0;
          n.st = dlps_pkg::ST_FETCH;
          n.mem = '{1'b1, 1'b0, s.onchip[c], s.pc[c], 32'h0};
        end
      end
      dlps_pkg::ST_FETCH: begin
        if (memAck) begin
          n.w[s.wIdx] = memRdata;
          if (3'(s.wIdx) + 3'h1 == dlps_pkg::instrLen(s.wIdx == 2'h0 ?
              memRdata[dlps_pkg::OPC_HI:dlps_pkg::OPC_LO] : op)) begin
            n.mem.req = 1'b0;
            n.st = dlps_pkg::ST_EXEC;
          end else begin
            n.wIdx = s.wIdx + 2'h1;
            n.mem.addr = s.mem.addr + 32'h4;
          end
        end
      end
      dlps_pkg::ST_EXEC: begin
        n.st = dlps_pkg::ST_DONE;
        if (mism) begin
          n.syncErr[s.chan] = 1'b1;
        end
        unique case (op)
          dlps_pkg::OP_STORE, dlps_pkg::OP_CSTORE, dlps_pkg::OP_FETCH,
          dlps_pkg::OP_CFETCH, dlps_pkg::OP_DISCARD: begin
            base = (op == dlps_pkg::OP_STORE || op == dlps_pkg::OP_FETCH) ?
                   s.w[1] : s.addr[s.chan];
            n.addr[s.chan] = base + 32'(cnt);
            n.inLine[s.chan] = !endF;
            n.beats = 11'((32'(cnt) + 32'h3) >> 2);
            n.mem = '{1'b0, 1'b0, 1'b0, base, 32'h0};
            if (cnt != 12'h0 && !(op == dlps_pkg::OP_DISCARD && isUp)) begin
              n.st = dlps_pkg::ST_XFER;
            end
          end
          dlps_pkg::OP_REGDUMP, dlps_pkg::OP_MASKWR: begin
            n.rg = '{1'b1, 1'b0, s.w[1][23:0], 32'h0};
            n.st = dlps_pkg::ST_REGRD;
          end
          dlps_pkg::OP_CONSTDUMP: begin
            n.mem = '{1'b1, 1'b1, 1'b0, s.w[2], s.w[1]};
            n.st = dlps_pkg::ST_HOSTWR;
          end
          default: begin
          end
        endcase
      end
      dlps_pkg::ST_XFER: begin
        if (op == dlps_pkg::OP_DISCARD) begin
          fifoPop = fifoOutValid;
          n.beats = s.beats - 11'(fifoOutValid);
        end else if (s.mem.req) begin
          if (memAck) begin
            n.mem.req = 1'b0;
            n.mem.addr = s.mem.addr + 32'h4;
            n.beats = s.beats - 11'h1;
            n.upValid = s.mem.we ? 1'b0 : 1'b1;
            n.upData = memRdata;
          end
        end else if (isUp) begin
          n.mem.req = fifoEnable[s.chan];
        end else if (fifoOutValid) begin
          fifoPop = 1'b1;
          n.mem.req = 1'b1;
          n.mem.we = 1'b1;
          n.mem.wdata = fifoData;
        end
        if (n.beats == 11'h0) begin
          n.st = dlps_pkg::ST_DONE;
        end
      end
      dlps_pkg::ST_REGRD: begin
        if (regAck) begin
          n.rg.req = 1'b0;
          n.regVal = regRdata;
          if (op == dlps_pkg::OP_MASKWR) begin
            n.rg = '{1'b1, 1'b1, s.w[1][23:0],
                     (regRdata & ~s.w[3]) | (s.w[2] & s.w[3])};
            n.st = dlps_pkg::ST_REGWR;
          end else begin
            n.mem = '{1'b1, 1'b1, 1'b0, s.w[2], regRdata};
            n.st = dlps_pkg::ST_HOSTWR;
          end
        end
      end
      dlps_pkg::ST_REGWR: begin
        if (regAck) begin
          n.rg.req = 1'b0;
          n.st = dlps_pkg::ST_DONE;
        end
      end
      dlps_pkg::ST_HOSTWR: begin
        if (memAck) begin
          n.mem.req = 1'b0;
          n.st = dlps_pkg::ST_DONE;
        end
      end
      dlps_pkg::ST_DONE: begin
        n.st = dlps_pkg::ST_IDLE;
        n.instr_interrupt_one[s.chan] = s.w[0][dlps_pkg::INSTR_INTERRUPT_ONE_BIT];
        n.instr_interrupt_two[s.chan] = s.w[0][dlps_pkg::INSTR_INTERRUPT_TWO_BIT];
        unique case (s.w[0][dlps_pkg::CNT_HI:dlps_pkg::CNT_LO])
          dlps_pkg::CNT_INC: n.evCnt[s.chan] = s.evCnt[s.chan] + 16'h1;
          dlps_pkg::CNT_CLR: n.evCnt[s.chan] = 16'h0;
          default: begin
          end
        endcase
        if (op == dlps_pkg::OP_BRANCH) begin
          n.onchip[s.chan] = s.w[0][dlps_pkg::ONCHIP_BIT];
          n.pc[s.chan] = s.w[0][dlps_pkg::ONCHIP_BIT] ?
                         {8'h0, s.w[1][23:0]} : s.w[1];
        end else begin
          n.pc[s.chan] = s.pc[s.chan] + {27'h0, dlps_pkg::instrLen(op), 2'h0};
        end
      end
    endcase
    if (s.st != dlps_pkg::ST_IDLE && !progEnable[s.chan]) begin
      n.st = dlps_pkg::ST_IDLE;
      n.mem.req = 1'b0;
      n.rg.req = 1'b0;
    end
    if (!sequencerRun) begin
      n = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign memOut = s.mem;
  assign regOut = s.rg;
  assign upValid = s.upValid;
  assign upData = s.upData;
  assign irqOne = s.instr_interrupt_one;
  assign irqTwo = s.instr_interrupt_two;
  assign syncErr = s.syncErr;
  assign evCount = s.evCnt;

  // ===========================================================
  // checks
  logic [31:0] pcCur;
  assign pcCur = s.pc[s.chan];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstnSync);

  a_run_holds_reset: assert property (!sequencerRun |=>
    s.st == dlps_pkg::ST_IDLE && !s.mem.req) else $error("run bit ignored");
  a_pc_advance_len: assert property (s.st == dlps_pkg::ST_DONE &&
    op != dlps_pkg::OP_BRANCH && sequencerRun && progEnable[s.chan] |=>
    pcCur == $past(pcCur) + {27'h0, dlps_pkg::instrLen($past(op)), 2'h0})
    else $error("pc not advanced by length");
  a_branch_loads_pc: assert property (s.st == dlps_pkg::ST_DONE &&
    op == dlps_pkg::OP_BRANCH && sequencerRun && progEnable[s.chan] |=>
    pcCur == ($past(s.w[0][dlps_pkg::ONCHIP_BIT]) ?
    {8'h0, $past(s.w[1][23:0])} : $past(s.w[1])))
    else $error("branch target wrong");
  a_irq_from_flag: assert property (s.st == dlps_pkg::ST_DONE &&
    sequencerRun |=> irqOne[$past(s.chan)] == $past(s.w[0][25]))
    else $error("interrupt flag lost");
  a_cnt_clear: assert property (s.st == dlps_pkg::ST_DONE &&
    s.w[0][17:16] == 2'h3 && sequencerRun |=> evCount[$past(s.chan)] == 16'h0)
    else $error("counter not cleared");
  a_sync_err_set: assert property (s.st == dlps_pkg::ST_EXEC && mism &&
    sequencerRun && progEnable[s.chan] |=> syncErr[$past(s.chan)])
    else $error("sync error missed");
  a_mask_merge: assert property (regOut.req && regOut.we |->
    regOut.wdata == ((s.regVal & ~s.w[3]) | (s.w[2] & s.w[3])))
    else $error("masked write wrong");
  a_disable_stops: assert property (s.st != dlps_pkg::ST_IDLE &&
    !progEnable[s.chan] |=> s.st == dlps_pkg::ST_IDLE && !memOut.req &&
    !regOut.req)
    else $error("disabled channel kept running");
  a_cont_address: assert property (s.st == dlps_pkg::ST_EXEC &&
    op == dlps_pkg::OP_CSTORE && sequencerRun && progEnable[s.chan] |=>
    memOut.addr == $past(s.addr[s.chan]))
    else $error("continue address wrong");

  c_store_beat: cover property (memOut.req && memOut.we && memAck);
  c_branch_done: cover property (s.st == dlps_pkg::ST_DONE &&
    op == dlps_pkg::OP_BRANCH);
  c_masked_write: cover property (regOut.req && regOut.we && regAck);
  c_sync_error: cover property (s.st == dlps_pkg::ST_EXEC && mism);
endmodule : dlps_top

// *** tb/dlps_host_model.sv ***
// Purpose: host memory and internal register model for the sequencer
// Assumes: one outstanding beat per port, requests held until ack
// Notes: ack delay drawn at random, 0 to 3 extra cycles
`timescale 1ns/1ns

module dlps_host_model (
  input wire logic clk,
  input wire dlps_pkg::dlps_mem_t memOut,
  output logic memAck,
  output logic [31:0] memRdata,
  input wire dlps_pkg::dlps_reg_t regOut,
  output logic regAck,
  output logic [31:0] regRdata
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] regs [logic [23:0]];
  logic [31:0] key;
  int mWait = 0;
  int rWait = 0;

  // on-chip words live in their own window of the map
  assign key = memOut.onchip ? {8'h80, memOut.addr[23:0]} : memOut.addr;

  initial begin
    memAck = 1'h0;
    regAck = 1'h0;
    memRdata = 32'h5a5a_5a5a;
    regRdata = 32'ha5a5_a5a5;
  end

  // ===========================================================
  // memory port
  // idle data toggles so a stale read never looks valid
  always @(posedge clk) begin
    if (memAck || !memOut.req) begin
      memAck <= 1'h0;
      memRdata <= ~memRdata;
    end else if (mWait > 0) begin
      mWait <= mWait - 1;
      memRdata <= ~memRdata;
    end else begin
      memAck <= 1'h1;
      if (memOut.we) mem[key] = memOut.wdata;
      memRdata <= memOut.we ? ~memRdata : mem[key];
      mWait <= $urandom_range(3);
    end
  end

  // ===========================================================
  // register port
  always @(posedge clk) begin
    if (regAck || !regOut.req) begin
      regAck <= 1'h0;
      regRdata <= ~regRdata;
    end else if (rWait > 0) begin
      rWait <= rWait - 1;
      regRdata <= ~regRdata;
    end else begin
      regAck <= 1'h1;
      if (regOut.we) regs[regOut.addr] = regOut.wdata;
      regRdata <= regOut.we ? ~regRdata : regs[regOut.addr];
      rWait <= $urandom_range(3);
    end
  end
endmodule : dlps_host_model

// *** tb/test_dlps_top.sv ***
// Purpose: self-checking bench of the line-program sequencer
// Assumes: host model answers both ports with random delays
// Notes: channel 0 runs downstream, channel 6 upstream
`timescale 1ns/1ns

module test_dlps_top;
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  logic sequencerRun = 1'h0;
  logic [11:0] progEnable = 12'h0;
  logic [11:0] fifoEnable = 12'h0;
  logic [11:0][31:0] initPc = '0;
  logic [11:0] initOnchip = 12'h0;
  logic [11:0] syncErrClr = 12'h0;
  logic periphValid = 1'h0;
  logic [3:0] periphChan = 4'h0;
  logic [31:0] periphData = 32'h0;
  dlps_pkg::dlps_mem_t memOut;
  dlps_pkg::dlps_reg_t regOut;
  logic memAck, regAck, periphReady, upValid;
  logic [31:0] memRdata, regRdata, upData;
  logic [11:0] irqOne, irqTwo, syncErr;
  logic [11:0][15:0] evCount;
  int failures = 0, num_checks = 0, cycles = 0, n1 = 0, n2 = 0, nReq;
  logic [31:0] upQ [$];
  logic [31:0] d [3];
  logic [31:0] k1, k2, msk, rv;

  always #10 core_clk = ~core_clk;

  dlps_top DUT (.core_clk(core_clk), .rstn(rstn),
    .sequencerRun(sequencerRun), .progEnable(progEnable),
    .fifoEnable(fifoEnable), .initPc(initPc), .initOnchip(initOnchip),
    .syncErrClr(syncErrClr), .memOut(memOut), .memAck(memAck),
    .memRdata(memRdata), .regOut(regOut), .regAck(regAck),
    .regRdata(regRdata), .periphValid(periphValid),
    .periphChan(periphChan), .periphData(periphData),
    .periphReady(periphReady), .upValid(upValid), .upData(upData),
    .irqOne(irqOne), .irqTwo(irqTwo), .syncErr(syncErr),
    .evCount(evCount));

  dlps_host_model HOST (.clk(core_clk), .memOut(memOut), .memAck(memAck),
    .memRdata(memRdata), .regOut(regOut), .regAck(regAck),
    .regRdata(regRdata));

  task automatic results();
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp,
      input string m);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk32

  task automatic chkFlags(input logic [11:0] got, input logic [11:0] exp,
      input string m);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chkFlags

  function automatic logic [31:0] ins(input logic [3:0] op,
      input logic [3:0] fl, input logic oc, input logic [1:0] cc,
      input logic [11:0] n);
    ins = {op, fl, oc, 5'h0, cc, 4'h0, n};
  endfunction : ins

  // valid stays up between pushes; caller lowers it
  task automatic push(input logic [31:0] v);
    periphValid <= 1'h1;
    periphData <= v;
    @(negedge core_clk);
    while (periphReady !== 1'h1) @(negedge core_clk);
    @(posedge core_clk);
  endtask : push

  task automatic waitFetch(input logic [31:0] a);
    @(negedge core_clk);
    while (!(memOut.req === 1'h1 && memOut.addr === a)) @(negedge core_clk);
  endtask : waitFetch

  // ===========================================================
  // monitors and timeout
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (upValid === 1'h1) upQ.push_back(upData);
    if (irqOne[0] === 1'h1) n1 <= n1 + 1;
    if (irqTwo[0] === 1'h1) n2 <= n2 + 1;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  // ===========================================================
  // main sequence
  initial begin
    void'($urandom(32'h41531767));
    foreach (d[i]) d[i] = $urandom();
    k1 = $urandom();
    k2 = $urandom();
    msk = $urandom();
    rv = $urandom();
    // upper target bits must be ignored on chip
    HOST.mem[32'h1000] = ins(dlps_pkg::OP_BRANCH, 4'h0, 1'h1, 2'h0, 12'h0);
    HOST.mem[32'h1004] = 32'hff00_0200;
    HOST.mem[32'h8000_0200] = ins(dlps_pkg::OP_STORE, 4'ha, 1'h0,
      dlps_pkg::CNT_INC, 12'h4);
    HOST.mem[32'h8000_0204] = 32'h2000;
    HOST.mem[32'h8000_0208] = ins(dlps_pkg::OP_DISCARD, 4'h0, 1'h0, 2'h0,
      12'h4);
    HOST.mem[32'h8000_020c] = ins(dlps_pkg::OP_CSTORE, 4'h5, 1'h0,
      dlps_pkg::CNT_INC, 12'h4);
    HOST.mem[32'h8000_0210] = ins(dlps_pkg::OP_DISCARD, 4'h4, 1'h0, 2'h0,
      12'h0);
    HOST.mem[32'h8000_0214] = ins(dlps_pkg::OP_CONSTDUMP, 4'h0, 1'h0,
      dlps_pkg::CNT_CLR, 12'h0);
    HOST.mem[32'h8000_0218] = k1;
    HOST.mem[32'h8000_021c] = 32'h3000;
    // register targets sit in an immediate range
    HOST.mem[32'h8000_0220] = ins(dlps_pkg::OP_REGDUMP, 4'h0, 1'h0,
      dlps_pkg::CNT_INC, 12'h0);
    HOST.mem[32'h8000_0224] = 32'h0033_c010;
    HOST.mem[32'h8000_0228] = 32'h3004;
    HOST.mem[32'h8000_022c] = ins(dlps_pkg::OP_MASKWR, 4'h0, 1'h0,
      dlps_pkg::CNT_INC, 12'h0);
    HOST.mem[32'h8000_0230] = 32'h0033_c010;
    HOST.mem[32'h8000_0234] = k2;
    HOST.mem[32'h8000_0238] = msk;
    HOST.mem[32'h8000_023c] = ins(dlps_pkg::OP_BRANCH, 4'h0, 1'h1, 2'h0,
      12'h0);
    HOST.mem[32'h8000_0240] = 32'h23c;
    HOST.mem[32'h2004] = 32'h0;
    HOST.regs[24'h33c010] = rv;
    HOST.mem[32'h4000] = ins(dlps_pkg::OP_FETCH, 4'h8, 1'h0, 2'h0, 12'h8);
    HOST.mem[32'h4004] = 32'h5000;
    HOST.mem[32'h4008] = ins(dlps_pkg::OP_CFETCH, 4'h4, 1'h0, 2'h0, 12'h4);
    HOST.mem[32'h400c] = ins(dlps_pkg::OP_BRANCH, 4'h0, 1'h0, 2'h0, 12'h0);
    HOST.mem[32'h4010] = 32'h400c;
    foreach (d[i]) HOST.mem[32'h5000 + 4 * i] = ~d[i];
    initPc[0] = 32'h1000;
    initPc[6] = 32'h4000;
    repeat (3) @(posedge core_clk);
    rstn <= 1'h1;
    repeat (3) @(posedge core_clk);
    sequencerRun <= 1'h1;
    // disabled FIFO must swallow this word
    push(32'hbad0_0bad);
    fifoEnable[0] <= 1'h1;
    foreach (d[i]) push(d[i]);
    periphValid <= 1'h0;
    // program enable only after full setup
    progEnable[0] <= 1'h1;
    waitFetch(32'h23c);
    chk32(HOST.mem[32'h2000], d[0], "store data");
    chk32(HOST.mem[32'h2004], 32'h0, "discarded hole");
    chk32(HOST.mem[32'h2008], d[2], "continue store");
    chk32(HOST.mem[32'h3000], k1, "constant dump");
    chk32(HOST.mem[32'h3004], rv, "register dump");
    chk32(HOST.regs[24'h33c010], (rv & ~msk) | (k2 & msk), "masked");
    chkFlags(syncErr, 12'h001, "sync error");
    chk32({16'h0, evCount[0]}, 32'h2, "event count");
    chk32(32'(n1), 32'h1, "irq one pulses");
    chk32(32'(n2), 32'h1, "irq two pulses");
    progEnable[0] <= 1'h0;
    syncErrClr <= 12'h001;
    @(posedge core_clk);
    syncErrClr <= 12'h0;
    repeat (3) @(posedge core_clk);
    nReq = 0;
    repeat (20) begin
      @(negedge core_clk);
      if (memOut.req !== 1'h0) nReq++;
    end
    chk32(32'(nReq), 32'h0, "requests after disable");
    chkFlags(syncErr, 12'h0, "sync error clear");
    // upstream FIFO enabled by software here
    fifoEnable[6] <= 1'h1;
    progEnable[6] <= 1'h1;
    waitFetch(32'h400c);
    repeat (3) @(posedge core_clk);
    chk32(32'(upQ.size()), 32'h3, "fetched beats");
    foreach (d[i]) chk32(upQ[i], ~d[i], "fetched data");
    chkFlags(syncErr, 12'h0, "upstream sync");
    sequencerRun <= 1'h0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk32({16'h0, evCount[0]}, 32'h0, "counter after stop");
    chk32({31'h0, memOut.req}, 32'h0, "request after stop");
    results();
  end
endmodule : test_dlps_top
